// [quad_cfg_pkg.sv]
// Behaviour
// R01: in 16-input mode converter 13 samples pair 25, or 26 when bit 11 set
// R02: in 16-input mode converter 14 samples pair 27, or 28 when bit 10 set
// R03: in 16-input mode converter 15 samples pair 29, or 30 when bit 9 set
// R04: in 16-input mode converter 16 samples pair 31, or 32 when bit 8 set
// R05: bits 7..5 pick lane 15 test pattern while per-lane pattern enable is set
// R06: bits 4..2 pick lane 16 test pattern while per-lane pattern enable is set
// R07: bits 15..12 power down digital blocks of converters 16..13
// R08: bits 11..8 power down serial output lanes 16..13
// R09: bits 7..4 power down analog blocks of converters 16..13
// R10: bits 3..0 invert conversion data on lanes 16..13
// R11: inversion touches conversion data only, test patterns pass unaltered
// R12: delay field shifts output clock in signed steps of 110 ps
// R13: code 0000 no shift, 0001 plus one step, 1111 minus one step
// R14: software writes zero to reserved bits; registers return what was written
// R15: every field resets to zero
`default_nettype none
package quad_cfg_pkg;
  // register offsets
  localparam logic [7:0] ADDR_INPUT_PATTERN = 8'h3B;
  localparam logic [7:0] ADDR_POWER_INVERT = 8'h3C;
  localparam logic [7:0] ADDR_CLOCK_DELAY = 8'h43;
  // reset values
  localparam logic [15:0] RST_INPUT_PATTERN = 16'h0000;
  localparam logic [15:0] RST_POWER_INVERT = 16'h0000;
  localparam logic [15:0] RST_CLOCK_DELAY = 16'h0000;
  // field positions, lane or channel index 0 stands for number 13
  localparam int STEER_TOP_BIT = 11;
  localparam int LANE15_PAT_LSB = 5;
  localparam int LANE16_PAT_LSB = 2;
  localparam int DIG_PDN_LSB = 12;
  localparam int LANE_PDN_LSB = 8;
  localparam int ANA_PDN_LSB = 4;
  localparam int INVERT_LSB = 0;
  localparam int DELAY_LSB = 1;
  // first input pair of converter 13; each converter owns two pairs
  localparam logic [5:0] PAIR_BASE = 6'h19;
  // output clock delay step in picoseconds
  localparam int DELAY_STEP_PS = 110;
  // test pattern codes
  localparam logic [2:0] PAT_DATA = 3'h0;
  localparam logic [2:0] PAT_ZEROS = 3'h1;
  localparam logic [2:0] PAT_ONES = 3'h2;
  localparam logic [2:0] PAT_TOGGLE_A = 3'h3;
  localparam logic [2:0] PAT_TOGGLE_B = 3'h4;
endpackage : quad_cfg_pkg
`default_nettype wire

// [lane_sel_if.sv]
`timescale 1ns/1ps
`default_nettype none
// per-lane controls from the register bank and the word chosen for the lane
interface lane_sel_if #(
  parameter int LANE_W = 14
);
  logic [2:0] code;
  logic patEn;
  logic invert;
  logic powerdown;
  logic [LANE_W-1:0] conv;
  logic [LANE_W-1:0] word;
  modport bank (output code, output patEn, output invert, output powerdown, output conv,
                input word);
  modport lane (input code, input patEn, input invert, input powerdown, input conv,
                output word);
endinterface : lane_sel_if
`default_nettype wire

// [lane_word_select.sv]
`timescale 1ns/1ps
`default_nettype none
module lane_word_select
  import quad_cfg_pkg::*;
#(
  parameter int LANE_W = 14
) (
  lane_sel_if.lane sel
);

  ////////////////////////////////////////////////////////////////////////////
  // pattern table; unknown codes fall back to conversion data
  function automatic logic [LANE_W-1:0] patternWord(input logic [2:0] code);
    logic [LANE_W-1:0] w;
    w = '0;
    for (int b = 0; b < LANE_W; b++) begin
      case (code)
        PAT_ONES: w[b] = 1'b1;
        PAT_TOGGLE_A: w[b] = b[0];
        PAT_TOGGLE_B: w[b] = ~b[0];
        default: w[b] = 1'b0;
      endcase
    end
    return w;
  endfunction : patternWord

  logic patActive;

  ////////////////////////////////////////////////////////////////////////////
  // a quiet lane sends zeros; patterns bypass the inverter
  assign patActive = sel.patEn && (sel.code != PAT_DATA) && (sel.code <= PAT_TOGGLE_B);
  always_comb begin
    if (sel.powerdown) begin
      sel.word = '0; // R08
    end else if (patActive) begin
      sel.word = patternWord(sel.code); // R11
    end else if (sel.invert) begin
      sel.word = ~sel.conv; // R10
    end else begin
      sel.word = sel.conv;
    end
  end

endmodule : lane_word_select
`default_nettype wire

// [adc_quad_channel_config.sv]
`timescale 1ns/1ps
`default_nettype none
module adc_quad_channel_config
  import quad_cfg_pkg::*;
#(
  parameter int LANE_W = 14,
  parameter int CHANNELS = 4
) (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic [7:0] regAddr,
  input wire logic [15:0] regWrData,
  input wire logic regWr,
  input wire logic regRd,
  output logic [15:0] regRdData,
  input wire logic inputMode16,
  input wire logic per_lane_pattern_enable,
  input wire logic [CHANNELS-1:0][LANE_W-1:0] convData,
  output logic [CHANNELS-1:0][LANE_W-1:0] laneData,
  output logic [CHANNELS-1:0][5:0] sampledPair,
  output logic [CHANNELS-1:0] inputPairSelect,
  output logic [CHANNELS-1:0] digitalPowerdown,
  output logic [CHANNELS-1:0] analogPowerdown,
  output logic [CHANNELS-1:0] lanePowerdown,
  output logic [CHANNELS-1:0] laneDataInvert,
  output logic [2:0] lane15_pattern_code,
  output logic [2:0] lane16_pattern_code,
  output logic [3:0] output_clock_delay_code,
  output logic signed [10:0] outputClockDelayPs
);

  ////////////////////////////////////////////////////////////////////////////
  // state

  typedef struct packed {
    logic [15:0] inputPattern;
    logic [15:0] powerInvert;
    logic [15:0] clockDelay;
    logic [15:0] rdData;
    logic [CHANNELS-1:0][5:0] pair;
    logic [CHANNELS-1:0][LANE_W-1:0] lanes;
    logic signed [10:0] delayPs;
  } state_t;

  state_t state_q;
  state_t state_d;

  logic [CHANNELS-1:0][LANE_W-1:0] laneWord;

  ////////////////////////////////////////////////////////////////////////////
  // helpers

  // readback mux, feeds the registered bus answer
  function automatic logic [15:0] readValue(input state_t s, input logic [7:0] addr);
    logic [15:0] v;
    v = 16'h0000;
    if (addr == ADDR_INPUT_PATTERN) begin
      v = s.inputPattern;
    end else if (addr == ADDR_POWER_INVERT) begin
      v = s.powerInvert;
    end else if (addr == ADDR_CLOCK_DELAY) begin
      v = s.clockDelay;
    end
    return v;
  endfunction : readValue

  // signed step count times the step size
  function automatic logic signed [10:0] delayOf(input logic [3:0] code);
    logic signed [15:0] p;
    p = 16'($signed(code)) * 16'(DELAY_STEP_PS);
    return p[10:0];
  endfunction : delayOf

  ////////////////////////////////////////////////////////////////////////////
  // field views of the registers, lane 13 at index 0

  genvar gi;
  generate
    for (gi = 0; gi < CHANNELS; gi++) begin : g_fields
      assign inputPairSelect[gi] = state_q.inputPattern[STEER_TOP_BIT - gi];
      assign digitalPowerdown[gi] = state_q.powerInvert[DIG_PDN_LSB + gi]; // R07
      assign lanePowerdown[gi] = state_q.powerInvert[LANE_PDN_LSB + gi]; // R08
      assign analogPowerdown[gi] = state_q.powerInvert[ANA_PDN_LSB + gi]; // R09
      assign laneDataInvert[gi] = state_q.powerInvert[INVERT_LSB + gi]; // R10
    end
  endgenerate

  assign lane15_pattern_code = state_q.inputPattern[LANE15_PAT_LSB +: 3]; // R05
  assign lane16_pattern_code = state_q.inputPattern[LANE16_PAT_LSB +: 3]; // R06
  assign output_clock_delay_code = state_q.clockDelay[DELAY_LSB +: 4]; // R12

  ////////////////////////////////////////////////////////////////////////////
  // lane word selection; lanes 13 and 14 have no test pattern and always select PAT_DATA

  generate
    for (gi = 0; gi < CHANNELS; gi++) begin : g_lane
      lane_sel_if #(.LANE_W(LANE_W)) sel ();
      if (gi == 2) begin : g_p15
        assign sel.code = lane15_pattern_code; // R05
      end else if (gi == 3) begin : g_p16
        assign sel.code = lane16_pattern_code; // R06
      end else begin : g_nop
        assign sel.code = PAT_DATA;
      end
      assign sel.patEn = per_lane_pattern_enable;
      assign sel.invert = laneDataInvert[gi];
      assign sel.powerdown = lanePowerdown[gi];
      assign sel.conv = convData[gi];
      assign laneWord[gi] = sel.word;
      lane_word_select #(.LANE_W(LANE_W)) u_sel (
        .sel(sel.lane)
      );
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // next state: register writes, read answer, steering and lane words

  always_comb begin
    state_d = state_q;
    // reserved bits are stored as written so readback matches
    if (regWr) begin
      if (regAddr == ADDR_INPUT_PATTERN) begin
        state_d.inputPattern = regWrData;
      end else if (regAddr == ADDR_POWER_INVERT) begin
        state_d.powerInvert = regWrData;
      end else if (regAddr == ADDR_CLOCK_DELAY) begin
        state_d.clockDelay = regWrData;
      end
    end
    // answer lives one cycle only, unmapped reads give zero
    state_d.rdData = regRd ? readValue(state_q, regAddr) : 16'h0000;
    for (int c = 0; c < CHANNELS; c++) begin
      // even pair of a converter only counts in 16-input mode
      state_d.pair[c] = PAIR_BASE + 6'(2 * c)
        + {5'h00, inputMode16 & inputPairSelect[c]}; // R01 R02 R03 R04
    end
    state_d.lanes = laneWord;
    state_d.delayPs = delayOf(output_clock_delay_code); // R12 R13
  end

  // all fields clear at reset: odd pairs, powered, no inversion, no delay
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_q.inputPattern <= RST_INPUT_PATTERN; // R15
      state_q.powerInvert <= RST_POWER_INVERT; // R15
      state_q.clockDelay <= RST_CLOCK_DELAY; // R15
      state_q.rdData <= 16'h0000;
      for (int c = 0; c < CHANNELS; c++) begin
        state_q.pair[c] <= PAIR_BASE + 6'(2 * c);
      end
      state_q.lanes <= '0;
      state_q.delayPs <= 11'sh000;
    end else begin
      state_q <= state_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs from flip-flops

  assign regRdData = state_q.rdData;
  assign laneData = state_q.lanes;
  assign sampledPair = state_q.pair;
  assign outputClockDelayPs = state_q.delayPs;

  ////////////////////////////////////////////////////////////////////////////
  // checks

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);

  property p_steer13;
    inputMode16 && state_q.inputPattern[11] |=> sampledPair[0] == 6'h1A;
  endproperty
  a_steer13: assert property (p_steer13) else $error("converter 13 not on pair 26"); // R01

  property p_steer14;
    inputMode16 && !state_q.inputPattern[10] |=> sampledPair[1] == 6'h1B;
  endproperty
  a_steer14: assert property (p_steer14) else $error("converter 14 not on pair 27"); // R02

  property p_steer15;
    inputMode16 && state_q.inputPattern[9] && !regWr [*2] |-> ##1 sampledPair[2] == 6'h1E;
  endproperty
  a_steer15: assert property (p_steer15) else $error("converter 15 not on pair 30"); // R03

  property p_steer16;
    !inputMode16 |=> sampledPair[3] == 6'h1F;
  endproperty
  a_steer16: assert property (p_steer16) else $error("converter 16 left pair 31"); // R04

  property p_pat15;
    per_lane_pattern_enable && lane15_pattern_code == PAT_ONES && !lanePowerdown[2]
      |=> laneData[2] == {LANE_W{1'b1}};
  endproperty
  a_pat15: assert property (p_pat15) else $error("lane 15 all-ones pattern missing"); // R05

  property p_pat16;
    !per_lane_pattern_enable && !laneDataInvert[3] && !lanePowerdown[3]
      |=> laneData[3] == $past(convData[3]);
  endproperty
  a_pat16: assert property (p_pat16) else $error("lane 16 pattern without enable"); // R06

  property p_digpdn;
    regWr && regAddr == ADDR_POWER_INVERT |=> digitalPowerdown == $past(regWrData[15:12])
      ##1 analogPowerdown == $past(regWrData[7:4], 2) || $past(regWr);
  endproperty
  a_digpdn: assert property (p_digpdn) else $error("power-down fields not loaded"); // R07

  property p_lanepdn;
    lanePowerdown[0] && $stable(lanePowerdown[0]) |=> laneData[0] == '0;
  endproperty
  a_lanepdn: assert property (p_lanepdn) else $error("powered-down lane 13 not quiet"); // R08

  property p_anapdn;
    regWr && regAddr == ADDR_POWER_INVERT |=> analogPowerdown == $past(regWrData[7:4]);
  endproperty
  a_anapdn: assert property (p_anapdn) else $error("analog power-down not loaded"); // R09

  property p_invert;
    laneDataInvert[1] && !lanePowerdown[1] |=> laneData[1] == ~$past(convData[1]);
  endproperty
  a_invert: assert property (p_invert) else $error("lane 14 data not inverted"); // R10

  property p_patnoinv;
    per_lane_pattern_enable && lane16_pattern_code == PAT_TOGGLE_A && laneDataInvert[3]
      && !lanePowerdown[3] |=> laneData[3][0] == 1'b0 && laneData[3][1] == 1'b1;
  endproperty
  a_patnoinv: assert property (p_patnoinv) else $error("test pattern was inverted"); // R11

  property p_delay;
    regWr && regAddr == ADDR_CLOCK_DELAY && regWrData[4:1] == 4'hF
      |=> ##1 outputClockDelayPs == -11'sd110;
  endproperty
  a_delay: assert property (p_delay) else $error("code 1111 not minus one step"); // R12 R13

  property p_readback;
    regRd && regAddr == ADDR_INPUT_PATTERN |=> regRdData == $past(state_q.inputPattern);
  endproperty
  a_readback: assert property (p_readback) else $error("readback differs from register"); // R14

  property p_steer13lo;
    inputMode16 && !state_q.inputPattern[11] |=> sampledPair[0] == 6'h19;
  endproperty
  a_steer13lo: assert property (p_steer13lo) else $error("converter 13 off pair 25"); // R01

  property p_steer14hi;
    inputMode16 && state_q.inputPattern[10] |=> sampledPair[1] == 6'h1C;
  endproperty
  a_steer14hi: assert property (p_steer14hi) else $error("converter 14 off pair 28"); // R02

  property p_steer15lo;
    inputMode16 && !state_q.inputPattern[9] |=> sampledPair[2] == 6'h1D;
  endproperty
  a_steer15lo: assert property (p_steer15lo) else $error("converter 15 off pair 29"); // R03

  property p_steer16hi;
    inputMode16 && state_q.inputPattern[8] |=> sampledPair[3] == 6'h20;
  endproperty
  a_steer16hi: assert property (p_steer16hi) else $error("converter 16 off pair 32"); // R04

  property p_pat15zero;
    per_lane_pattern_enable && lane15_pattern_code == PAT_ZEROS && !lanePowerdown[2]
      |=> laneData[2] == '0;
  endproperty
  a_pat15zero: assert property (p_pat15zero) else $error("lane 15 zeros missing"); // R05

  property p_pat15off;
    !per_lane_pattern_enable && !laneDataInvert[2] && !lanePowerdown[2]
      |=> laneData[2] == $past(convData[2]);
  endproperty
  a_pat15off: assert property (p_pat15off) else $error("lane 15 pattern without enable"); // R05

  property p_pat16ones;
    per_lane_pattern_enable && lane16_pattern_code == PAT_ONES && !lanePowerdown[3]
      |=> laneData[3] == {LANE_W{1'b1}};
  endproperty
  a_pat16ones: assert property (p_pat16ones) else $error("lane 16 ones missing"); // R06

  property p_pat16alt;
    per_lane_pattern_enable && lane16_pattern_code == PAT_TOGGLE_B && !lanePowerdown[3]
      |=> laneData[3][0] == 1'b1 && laneData[3][1] == 1'b0;
  endproperty
  a_pat16alt: assert property (p_pat16alt) else $error("lane 16 alternating pattern wrong"); // R06

  property p_digstable;
    !(regWr && regAddr == ADDR_POWER_INVERT) |=> $stable(digitalPowerdown);
  endproperty
  a_digstable: assert property (p_digstable) else $error("digital power-down moved"); // R07

  property p_lanepdn16;
    lanePowerdown[3] |=> laneData[3] == '0;
  endproperty
  a_lanepdn16: assert property (p_lanepdn16) else $error("powered-down lane 16 not quiet"); // R08

  property p_anastable;
    !(regWr && regAddr == ADDR_POWER_INVERT) |=> $stable(analogPowerdown);
  endproperty
  a_anastable: assert property (p_anastable) else $error("analog power-down moved"); // R09

  property p_invert13;
    laneDataInvert[0] && !lanePowerdown[0] |=> laneData[0] == ~$past(convData[0]);
  endproperty
  a_invert13: assert property (p_invert13) else $error("lane 13 data not inverted"); // R10

  property p_patnoinv15;
    per_lane_pattern_enable && lane15_pattern_code == PAT_ONES && laneDataInvert[2]
      && !lanePowerdown[2] |=> laneData[2] == {LANE_W{1'b1}};
  endproperty
  a_patnoinv15: assert property (p_patnoinv15) else $error("lane 15 pattern inverted"); // R11

  property p_delayzero;
    output_clock_delay_code == 4'h0 |=> outputClockDelayPs == 11'sh000;
  endproperty
  a_delayzero: assert property (p_delayzero) else $error("code 0000 shifted the clock"); // R13

  property p_delayplus;
    output_clock_delay_code == 4'h1 |=> outputClockDelayPs == 11'sh06E;
  endproperty
  a_delayplus: assert property (p_delayplus) else $error("code 0001 not plus one step"); // R12 R13

  property p_delayload;
    regWr && regAddr == ADDR_CLOCK_DELAY |=> output_clock_delay_code == $past(regWrData[4:1]);
  endproperty
  a_delayload: assert property (p_delayload) else $error("delay code not loaded"); // R12

  property p_rdidle;
    !regRd |=> regRdData == 16'h0000;
  endproperty
  a_rdidle: assert property (p_rdidle) else $error("read answer outside its cycle"); // R14

  property p_rdback3c;
    regRd && regAddr == ADDR_POWER_INVERT |=> regRdData == $past(state_q.powerInvert);
  endproperty
  a_rdback3c: assert property (p_rdback3c) else $error("power register readback wrong"); // R14

  property p_rdback43;
    regRd && regAddr == ADDR_CLOCK_DELAY |=> regRdData == $past(state_q.clockDelay);
  endproperty
  a_rdback43: assert property (p_rdback43) else $error("delay register readback wrong"); // R14

  property p_rdunmapped;
    regRd && regAddr != ADDR_INPUT_PATTERN && regAddr != ADDR_POWER_INVERT
      && regAddr != ADDR_CLOCK_DELAY |=> regRdData == 16'h0000;
  endproperty
  a_rdunmapped: assert property (p_rdunmapped) else $error("unmapped read not zero"); // R14

endmodule : adc_quad_channel_config
`default_nettype wire

// [tb.sv]
`timescale 1ns/1ps
`default_nettype none
module tb
  import quad_cfg_pkg::*;
;
  logic core_clk = 1'b0;
  logic rst_n = 1'b0;
  logic [7:0] regAddr = 8'h00;
  logic [15:0] regWrData = 16'h0000;
  logic regWr = 1'b0;
  logic regRd = 1'b0;
  logic [15:0] regRdData;
  logic inputMode16 = 1'b0;
  logic patEn = 1'b0;
  logic [3:0][13:0] convData = '0;
  logic [3:0][13:0] laneData;
  logic [3:0][5:0] sampledPair;
  logic [3:0] pairSel, digPdn, anaPdn, lanePdn, laneInv;
  logic [2:0] code15, code16;
  logic [3:0] delayCode;
  logic signed [10:0] delayPs;
  int fails = 0;
  int comparisons = 0;
  int cycles = 0;
  logic [31:0] seed = 32'h00010D59;
  logic [15:0] rd, r3b, r3c, rv;

  adc_quad_channel_config #(.LANE_W(14), .CHANNELS(4)) dut (.core_clk(core_clk), .rst_n(rst_n),
    .regAddr(regAddr), .regWrData(regWrData), .regWr(regWr), .regRd(regRd),
    .regRdData(regRdData), .inputMode16(inputMode16), .per_lane_pattern_enable(patEn),
    .convData(convData), .laneData(laneData), .sampledPair(sampledPair),
    .inputPairSelect(pairSel), .digitalPowerdown(digPdn), .analogPowerdown(anaPdn),
    .lanePowerdown(lanePdn), .laneDataInvert(laneInv), .lane15_pattern_code(code15),
    .lane16_pattern_code(code16), .output_clock_delay_code(delayCode),
    .outputClockDelayPs(delayPs));

  ////////////////////////////////////////////////////////////////////////////////
  // 25 ns period; the ceiling is far above the few hundred cycles the tests need
  always #12.5 core_clk = ~core_clk;
  always @(posedge core_clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      fails = fails + 1;
      finish_test();
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // random source: galois shift register, fixed start value for repeatable runs
  function automatic logic [15:0] rnd();
    seed = seed[0] ? ((seed >> 1) ^ 32'h80200003) : (seed >> 1);
    return seed[15:0];
  endfunction : rnd

  // expected lane word: powerdown wins, then uninverted pattern, then data
  function automatic logic [13:0] exp_lane(int i, logic [13:0] d, logic [15:0] c3b,
                                           logic [15:0] c3c, logic en);
    logic [2:0] c;
    c = (i == 2) ? c3b[7:5] : c3b[4:2];
    if (c3c[8+i]) return 14'h0000;
    if (i >= 2 && en) begin
      case (c)
        3'h1: return 14'h0000;
        3'h2: return 14'h3FFF;
        3'h3: return 14'h2AAA;
        3'h4: return 14'h1555;
        default: ;
      endcase
    end
    return c3c[i] ? ~d : d;
  endfunction : exp_lane

  task automatic check(input logic [15:0] seen, input logic [15:0] want, input string what);
    comparisons = comparisons + 1;
    if (seen !== want) begin
      fails = fails + 1;
      $display("CHECK FAILED %0t: %s seen %h want %h", $time, what, seen, want);
    end
  endtask : check

  task automatic finish_test();
    $display("comparisons %0d fails %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : finish_test

  ////////////////////////////////////////////////////////////////////////////////
  // bus tasks: strobes one cycle long, read data taken in the following cycle
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge core_clk);
    regWr <= 1'b1;
    regAddr <= a;
    regWrData <= d;
    @(posedge core_clk);
    regWr <= 1'b0;
  endtask : wr

  task automatic rdreg(input logic [7:0] a, output logic [15:0] d);
    @(posedge core_clk);
    regRd <= 1'b1;
    regAddr <= a;
    @(posedge core_clk);
    regRd <= 1'b0;
    @(negedge core_clk);
    d = regRdData;
  endtask : rdreg

  task automatic do_reset();
    rst_n <= 1'b0;
    repeat (8) @(posedge core_clk);
    rst_n <= 1'b1;
  endtask : do_reset

  // every register, the power outputs and the delay in ps back at zero after reset, pairs at 25, 27, 29, 31
  task automatic check_reset();
    rdreg(ADDR_INPUT_PATTERN, rd);
    check(rd, RST_INPUT_PATTERN, "reset 3b");
    rdreg(ADDR_POWER_INVERT, rd);
    check(rd, RST_POWER_INVERT, "reset 3c");
    rdreg(ADDR_CLOCK_DELAY, rd);
    check(rd, RST_CLOCK_DELAY, "reset 43");
    check({digPdn, anaPdn, lanePdn, laneInv}, 16'h0000, "reset power");
    check(16'(delayPs), 16'h0000, "reset delay");
    for (int i = 0; i < 4; i++) check(16'(sampledPair[i]), 16'(25 + 2 * i), "reset pair");
  endtask : check_reset

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    do_reset();
    check_reset();
    // readback, unmapped read and an ignored unmapped write
    for (int k = 0; k < 6; k++) begin
      r3c = rnd();
      wr(ADDR_POWER_INVERT, r3c);
      rdreg(ADDR_POWER_INVERT, rd);
      check(rd, r3c, "readback 3c");
      r3b = rnd() & 16'h0FFC;
      wr(ADDR_INPUT_PATTERN, r3b);
      wr(8'h3D, 16'hFFFF);
      rdreg(ADDR_INPUT_PATTERN, rd);
      check(rd, r3b, "readback 3b");
      rdreg(8'h3D, rd);
      check(rd, 16'h0000, "unmapped read");
    end
    $display("test registers done");
    // field outputs and lane words under random config, first codes forced 0..7
    for (int k = 0; k < 40; k++) begin
      r3b = rnd() & 16'h0FFC;
      if (k < 8) r3b[7:5] = 3'(k);
      if (k < 8) r3b[4:2] = 3'(7 - k);
      r3c = (k < 8) ? {rnd() & 16'h00FF} : rnd();
      wr(ADDR_INPUT_PATTERN, r3b);
      wr(ADDR_POWER_INVERT, r3c);
      @(posedge core_clk);
      rv = rnd();
      inputMode16 <= (k < 8) ? 1'b1 : rv[0];
      patEn <= (k < 8) ? 1'b1 : rv[1];
      for (int i = 0; i < 4; i++) begin
        rv = rnd();
        convData[i] <= rv[13:0];
      end
      @(posedge core_clk);
      @(negedge core_clk);
      check(16'(code15), 16'(r3b[7:5]), "code15");
      check(16'(code16), 16'(r3b[4:2]), "code16");
      for (int i = 0; i < 4; i++) begin
        check(16'(pairSel[i]), 16'(r3b[11-i]), "pair select");
        check(16'(sampledPair[i]), 16'(25 + 2 * i + (inputMode16 & r3b[11-i])), "pair");
        check(16'(digPdn[i]), 16'(r3c[12+i]), "dig pdn");
        check(16'(lanePdn[i]), 16'(r3c[8+i]), "lane pdn");
        check(16'(anaPdn[i]), 16'(r3c[4+i]), "ana pdn");
        check(16'(laneInv[i]), 16'(r3c[i]), "invert");
        check(16'(laneData[i]), 16'(exp_lane(i, convData[i], r3b, r3c, patEn)), "lane");
      end
    end
    $display("test datapath done");
    // every delay code, signed steps of 110 ps
    for (int c = 0; c < 16; c++) begin
      wr(ADDR_CLOCK_DELAY, 16'(c << DELAY_LSB));
      rdreg(ADDR_CLOCK_DELAY, rd);
      check(rd, 16'(c << 1), "readback 43");
      @(negedge core_clk);
      check(16'(delayCode), 16'(c), "delay code");
      check(16'(delayPs), 16'(11'($signed(4'(c)) * DELAY_STEP_PS)), "delay ps");
    end
    $display("test delay done");
    // reset in mid-run clears everything again; driven from a rising edge
    @(posedge core_clk);
    do_reset();
    check_reset();
    $display("test second reset done");
    finish_test();
  end
endmodule : tb
`default_nettype wire
